/* File: rtl/smbarp_pkg.sv */
package smbarp_pkg;
  // Default bus address, seven bits
  localparam logic [6:0] DEF_ADDR = 7'h61;
  // General command codes
  localparam logic [7:0] CMD_GEN_RESET = 8'h02;
  localparam logic [7:0] CMD_GET_UNIQUE_DEVICE_IDENTIFIER = 8'h03;
  localparam logic [7:0] CMD_ASSIGN = 8'h04;
  localparam logic [7:0] CMD_GENERAL_MAX = 8'h1f;
  localparam logic [7:0] CMD_DIRECTED_MAX = 8'hfd;
  // Block byte count and reply layout
  localparam logic [7:0] UNIQUE_DEVICE_IDENTIFIER_COUNT = 8'h11;
  localparam logic [4:0] IDX_COUNT = 5'h00;
  localparam logic [4:0] IDX_UNIQUE_DEVICE_IDENTIFIER_POS = 5'h10;
  localparam logic [4:0] IDX_ADDR = 5'h11;
  localparam logic [4:0] IDX_PEC = 5'h12;
  localparam logic [4:0] IDX_UNIQUE_DEVICE_IDENTIFIER_TOP = 5'h0f;
  localparam logic [4:0] IDX_ZERO = 5'h00;
  localparam logic [4:0] IDX_STEP = 5'h01;
  // Reply address when no valid address is held
  localparam logic [7:0] ADDR_INVALID_BYTE = 8'hff;
  // Checksum
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [6:0] ADDR_RESET = 7'h7f;

  typedef enum logic [9:0] {
    ST_IDLE      = 10'h001,
    ST_CMD       = 10'h002,
    ST_RESET_PEC = 10'h004,
    ST_UNIQUE_DEVICE_IDENTIFIER_WAIT = 10'h008,
    ST_SEND      = 10'h010,
    ST_AA_COUNT  = 10'h020,
    ST_AA_UNIQUE_DEVICE_IDENTIFIER   = 10'h040,
    ST_AA_ADDR   = 10'h080,
    ST_AA_PEC    = 10'h100,
    ST_IGNORE    = 10'h200
  } smbarp_state_t;
endpackage

/* File: rtl/smbarp_slave.sv */
`timescale 1ns/1ps
// Summary of operation
// [RULE1] Resets are send-byte with checksum to default
// [RULE2] General reset clears resolved; valid unless persistent
// [RULE3] Accepted reset requests a new random field
// [RULE4] General reset bytes are always acknowledged
// [RULE5] Master treats missing ack as no device
// [RULE6] Resets touch only resolution state, nothing else
// [RULE7] General identifier query answered only while unresolved
// [RULE8] Reply: count, identifier high to low, address, checksum
// [RULE9] Reply address byte lsb is always one
// [RULE10] Invalid address replies all ones in upper bits
// [RULE11] Master treats early nack as none left
// [RULE12] Identifier mismatch during assign nacks that byte
// [RULE13] Last identifier mismatch nacks last identifier byte
// [RULE14] Full match adopts address, sets flags, persists
// [RULE15] Assigned address lsb is ignored
// [RULE16] Assign is processed even when already resolved
// [RULE17] Bad assign checksum is nacked and discarded
// [RULE18] Master treats assign nack as device absent
// [RULE19] Directed identifier query answered only when valid
// [RULE20] Directed reset needs own address and valid flag
// [RULE21] Master treats directed nack as no device
// [RULE22] Directed command: address in bits seven to one
// [RULE23] Identifier query is 03, assign is 04
// [RULE24] Reply byte count is seventeen
// [RULE25] Checksum is crc8 over every byte incl. addresses
// [RULE26] Assign is block write: count, identifier, address
module smbarp_slave (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Byte layer events
  input wire logic frameStart,
  input wire logic frameStop,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic txReq,
  input wire logic txNack,
  // Byte layer answers
  output logic ackValid,
  output logic ackOk,
  output logic txValid,
  output logic [7:0] txData,
  // Device options and identity
  input wire logic [127:0] uniqueDeviceIdentifier,
  input wire logic persistentAddressOption,
  input wire logic randomNumberOption,
  input wire logic persistValidIn,
  input wire logic [6:0] persistAddrIn,
  // Resolution state
  output logic addressResolvedFlag,
  output logic addressValidFlag,
  output logic [6:0] slaveAddress,
  output logic persistWrite,
  output logic [6:0] persistAddrOut,
  output logic randomRegen
);

  function automatic logic [7:0] crc8Next(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ smbarp_pkg::CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  function automatic logic [7:0] udidByte(input logic [127:0] u,
                                          input logic [3:0] i);
    return u[{i, 3'b000} +: 8];
  endfunction

  smbarp_pkg::smbarp_state_t state_q, state_d;
  logic expectAddr_q, directed_q, loadPending_q;
  logic [7:0] crc_q;
  logic [4:0] byteIdx_q, sentIdx_q;
  logic [6:0] newAddr_q, slaveAddr_q, persistAddr_q;
  logic ar_q, av_q, ackValid_q, ackOk_q, txValid_q;
  logic persistWrite_q, randomRegen_q;
  logic [7:0] txData_q;
  logic rxAck;

  // Byte decoding
  wire dataByte = rxValid && !expectAddr_q;
  wire [7:0] writeAddr = {smbarp_pkg::DEF_ADDR, 1'b0};
  wire [7:0] readAddr = {smbarp_pkg::DEF_ADDR, 1'b1};
  wire isGenReset = rxData == smbarp_pkg::CMD_GEN_RESET;
  wire isGetUdid = rxData == smbarp_pkg::CMD_GET_UNIQUE_DEVICE_IDENTIFIER;
  wire isAssign = rxData == smbarp_pkg::CMD_ASSIGN;
  wire directedMine = rxData > smbarp_pkg::CMD_GENERAL_MAX
    && rxData <= smbarp_pkg::CMD_DIRECTED_MAX
    && rxData[7:1] == slaveAddr_q && av_q; // [RULE22] [RULE19] [RULE20]
  wire pecMatch = rxData == crc_q; // [RULE25]
  wire udidMatch = rxData
    == udidByte(uniqueDeviceIdentifier, byteIdx_q[3:0]); // [RULE12]
  wire lastUdid = byteIdx_q == smbarp_pkg::IDX_ZERO;
  wire inSend = state_q == smbarp_pkg::ST_SEND;
  wire keepCrc = state_q == smbarp_pkg::ST_UNIQUE_DEVICE_IDENTIFIER_WAIT;
  wire resetAccept = dataByte && state_q == smbarp_pkg::ST_RESET_PEC
    && pecMatch;
  wire assignAccept = dataByte && state_q == smbarp_pkg::ST_AA_PEC
    && pecMatch; // [RULE17]

  // Reply byte selection
  wire [4:0] udidPos = smbarp_pkg::IDX_UNIQUE_DEVICE_IDENTIFIER_POS - byteIdx_q;
  wire [7:0] replyAddr = av_q ? {slaveAddr_q, 1'b1}
    : smbarp_pkg::ADDR_INVALID_BYTE; // [RULE9] [RULE10]
  wire [7:0] txByteSel =
    (byteIdx_q == smbarp_pkg::IDX_COUNT) ? smbarp_pkg::UNIQUE_DEVICE_IDENTIFIER_COUNT :
    (byteIdx_q == smbarp_pkg::IDX_ADDR) ? replyAddr :
    (byteIdx_q >= smbarp_pkg::IDX_PEC) ? crc_q :
    udidByte(uniqueDeviceIdentifier, udidPos[3:0]); // [RULE8] [RULE24]

  // Command sequencing and ack decision
  always_comb begin
    state_d = state_q;
    rxAck = 1'b0;
    if (rxValid && expectAddr_q) begin
      if (state_q == smbarp_pkg::ST_UNIQUE_DEVICE_IDENTIFIER_WAIT && rxData == readAddr) begin
        rxAck = 1'b1;
        state_d = smbarp_pkg::ST_SEND;
      end else if (state_q == smbarp_pkg::ST_IDLE && rxData == writeAddr) begin
        rxAck = 1'b1; // [RULE1]
        state_d = smbarp_pkg::ST_CMD;
      end else begin
        state_d = smbarp_pkg::ST_IGNORE;
      end
    end else if (rxValid) begin
      case (state_q)
        smbarp_pkg::ST_CMD: begin
          if (isGenReset) begin
            rxAck = 1'b1; // [RULE4]
            state_d = smbarp_pkg::ST_RESET_PEC;
          end else if (isGetUdid && !ar_q) begin
            rxAck = 1'b1; // [RULE7] [RULE23]
            state_d = smbarp_pkg::ST_UNIQUE_DEVICE_IDENTIFIER_WAIT;
          end else if (isAssign) begin
            rxAck = 1'b1; // [RULE16] [RULE23]
            state_d = smbarp_pkg::ST_AA_COUNT;
          end else if (directedMine) begin
            rxAck = 1'b1; // [RULE22]
            state_d = rxData[0] ? smbarp_pkg::ST_UNIQUE_DEVICE_IDENTIFIER_WAIT
              : smbarp_pkg::ST_RESET_PEC;
          end else begin
            state_d = smbarp_pkg::ST_IGNORE;
          end
        end
        smbarp_pkg::ST_RESET_PEC: begin
          rxAck = pecMatch || !directed_q; // [RULE4] [RULE20]
          state_d = smbarp_pkg::ST_IGNORE;
        end
        smbarp_pkg::ST_AA_COUNT: begin
          rxAck = rxData == smbarp_pkg::UNIQUE_DEVICE_IDENTIFIER_COUNT; // [RULE26]
          state_d = rxAck ? smbarp_pkg::ST_AA_UNIQUE_DEVICE_IDENTIFIER : smbarp_pkg::ST_IGNORE;
        end
        smbarp_pkg::ST_AA_UNIQUE_DEVICE_IDENTIFIER: begin
          rxAck = udidMatch; // [RULE12] [RULE13]
          state_d = !udidMatch ? smbarp_pkg::ST_IGNORE :
            lastUdid ? smbarp_pkg::ST_AA_ADDR : smbarp_pkg::ST_AA_UNIQUE_DEVICE_IDENTIFIER;
        end
        smbarp_pkg::ST_AA_ADDR: begin
          rxAck = 1'b1;
          state_d = smbarp_pkg::ST_AA_PEC;
        end
        smbarp_pkg::ST_AA_PEC: begin
          rxAck = pecMatch; // [RULE17]
          state_d = smbarp_pkg::ST_IGNORE;
        end
        default: begin
          state_d = smbarp_pkg::ST_IGNORE;
        end
      endcase
    end
    if (inSend && (txNack
        || (txReq && byteIdx_q >= smbarp_pkg::IDX_PEC))) begin
      state_d = smbarp_pkg::ST_IGNORE;
    end
    if (frameStop || (frameStart && !keepCrc)) begin
      state_d = smbarp_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= smbarp_pkg::ST_IDLE;
      expectAddr_q <= 1'b0;
      directed_q <= 1'b0;
    end else begin
      state_q <= state_d;
      expectAddr_q <= frameStart || (expectAddr_q && !rxValid && !frameStop);
      if (dataByte && state_q == smbarp_pkg::ST_CMD) begin
        directed_q <= !isGenReset;
      end
    end
  end

  // Checksum over received and sent bytes
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      crc_q <= smbarp_pkg::CRC_INIT;
    end else if (frameStart && !keepCrc) begin
      crc_q <= smbarp_pkg::CRC_INIT;
    end else if (rxValid) begin
      crc_q <= crc8Next(crc_q, rxData); // [RULE25]
    end else if (txReq && inSend) begin
      crc_q <= crc8Next(crc_q, txByteSel); // [RULE25]
    end
  end

  // Byte index for reply and identifier compare
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      byteIdx_q <= smbarp_pkg::IDX_ZERO;
    end else if (state_q == smbarp_pkg::ST_UNIQUE_DEVICE_IDENTIFIER_WAIT) begin
      byteIdx_q <= smbarp_pkg::IDX_ZERO;
    end else if (state_q == smbarp_pkg::ST_AA_COUNT) begin
      byteIdx_q <= smbarp_pkg::IDX_UNIQUE_DEVICE_IDENTIFIER_TOP;
    end else if (txReq && inSend) begin
      byteIdx_q <= byteIdx_q + smbarp_pkg::IDX_STEP;
    end else if (dataByte && state_q == smbarp_pkg::ST_AA_UNIQUE_DEVICE_IDENTIFIER) begin
      byteIdx_q <= byteIdx_q - smbarp_pkg::IDX_STEP;
    end
  end

  // Resolution flags and address; nothing else is reset here
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      loadPending_q <= 1'b1;
      ar_q <= 1'b0;
      av_q <= 1'b0;
      slaveAddr_q <= smbarp_pkg::ADDR_RESET;
      newAddr_q <= smbarp_pkg::ADDR_RESET;
    end else begin
      loadPending_q <= 1'b0;
      if (dataByte && state_q == smbarp_pkg::ST_AA_ADDR) begin
        newAddr_q <= rxData[7:1]; // [RULE15]
      end
      if (loadPending_q) begin
        av_q <= persistentAddressOption && persistValidIn;
        slaveAddr_q <= persistAddrIn;
      end else if (assignAccept) begin
        slaveAddr_q <= newAddr_q; // [RULE14]
        ar_q <= 1'b1; // [RULE14]
        av_q <= 1'b1; // [RULE14]
      end else if (resetAccept) begin
        ar_q <= 1'b0; // [RULE2] [RULE20] [RULE6]
        if (!persistentAddressOption) begin
          av_q <= 1'b0; // [RULE2] [RULE20]
        end
      end
    end
  end

  // Answers to the byte layer and side effects
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ackValid_q <= 1'b0;
      ackOk_q <= 1'b0;
      txValid_q <= 1'b0;
      txData_q <= smbarp_pkg::CRC_INIT;
      sentIdx_q <= smbarp_pkg::IDX_ZERO;
      persistWrite_q <= 1'b0;
      persistAddr_q <= smbarp_pkg::ADDR_RESET;
      randomRegen_q <= 1'b0;
    end else begin
      ackValid_q <= rxValid;
      ackOk_q <= rxAck;
      txValid_q <= txReq && inSend;
      txData_q <= txByteSel;
      sentIdx_q <= byteIdx_q;
      persistWrite_q <= assignAccept && persistentAddressOption; // [RULE14]
      persistAddr_q <= newAddr_q;
      randomRegen_q <= resetAccept && randomNumberOption; // [RULE3]
    end
  end

  assign ackValid = ackValid_q;
  assign ackOk = ackOk_q;
  assign txValid = txValid_q;
  assign txData = txData_q;
  assign addressResolvedFlag = ar_q;
  assign addressValidFlag = av_q;
  assign slaveAddress = slaveAddr_q;
  assign persistWrite = persistWrite_q;
  assign persistAddrOut = persistAddr_q;
  assign randomRegen = randomRegen_q;

  // Checks
  wire genResetPec = dataByte && state_q == smbarp_pkg::ST_RESET_PEC
    && !directed_q;
  wire cmdByte = dataByte && state_q == smbarp_pkg::ST_CMD;

  sequence s_ackGiven;
    ackValid && ackOk;
  endsequence
  sequence s_nackGiven;
    ackValid && !ackOk;
  endsequence

  property p_gen_reset_ack;
    @(posedge sys_clk) disable iff (!reset_n)
      (genResetPec || (cmdByte && isGenReset)) |=> s_ackGiven;
  endproperty
  a_gen_reset_ack: assert property (p_gen_reset_ack) // [RULE4]
    else $error("general reset byte not acked");

  property p_reset_flags;
    @(posedge sys_clk) disable iff (!reset_n)
      resetAccept && !loadPending_q |=> !ar_q
        && (av_q == ($past(av_q) && persistentAddressOption));
  endproperty
  a_reset_flags: assert property (p_reset_flags) // [RULE2]
    else $error("reset flag update wrong");

  property p_random;
    @(posedge sys_clk) disable iff (!reset_n)
      resetAccept && randomNumberOption |=> randomRegen ##1 !randomRegen;
  endproperty
  a_random: assert property (p_random) // [RULE3]
    else $error("random regen pulse missing");

  property p_unique_device_identifier_nack_resolved;
    @(posedge sys_clk) disable iff (!reset_n)
      cmdByte && isGetUdid && ar_q |=> s_nackGiven;
  endproperty
  a_unique_device_identifier_nack_resolved: assert property (p_unique_device_identifier_nack_resolved) // [RULE7]
    else $error("query acked while resolved");

  property p_reply_addr;
    @(posedge sys_clk) disable iff (!reset_n)
      txValid && sentIdx_q == smbarp_pkg::IDX_ADDR |->
        txData[0] && (av_q || txData == smbarp_pkg::ADDR_INVALID_BYTE);
  endproperty
  a_reply_addr: assert property (p_reply_addr) // [RULE9] [RULE10]
    else $error("reply address byte wrong");

  property p_reply_count;
    @(posedge sys_clk) disable iff (!reset_n)
      txValid && sentIdx_q == smbarp_pkg::IDX_COUNT |->
        txData == smbarp_pkg::UNIQUE_DEVICE_IDENTIFIER_COUNT;
  endproperty
  a_reply_count: assert property (p_reply_count) // [RULE24]
    else $error("reply count wrong");

  property p_unique_device_identifier_mismatch;
    @(posedge sys_clk) disable iff (!reset_n)
      dataByte && state_q == smbarp_pkg::ST_AA_UNIQUE_DEVICE_IDENTIFIER && !udidMatch
        |=> s_nackGiven ##1 (state_q == smbarp_pkg::ST_IGNORE || frameStop);
  endproperty
  a_unique_device_identifier_mismatch: assert property (p_unique_device_identifier_mismatch) // [RULE12]
    else $error("mismatch not nacked");

  property p_assign_commit;
    @(posedge sys_clk) disable iff (!reset_n)
      assignAccept && !loadPending_q |=> s_ackGiven and (ar_q && av_q
        && slaveAddress == $past(newAddr_q));
  endproperty
  a_assign_commit: assert property (p_assign_commit) // [RULE14]
    else $error("assign not committed");

  property p_assign_bad_pec;
    @(posedge sys_clk) disable iff (!reset_n)
      dataByte && state_q == smbarp_pkg::ST_AA_PEC && !pecMatch
        && !loadPending_q |=> s_nackGiven and ($stable(slaveAddr_q));
  endproperty
  a_assign_bad_pec: assert property (p_assign_bad_pec) // [RULE17]
    else $error("bad checksum assign accepted");

  property p_directed_invalid;
    @(posedge sys_clk) disable iff (!reset_n)
      cmdByte && !av_q && rxData > smbarp_pkg::CMD_GENERAL_MAX
        |=> s_nackGiven;
  endproperty
  a_directed_invalid: assert property (p_directed_invalid) // [RULE19] [RULE20]
    else $error("directed command acked without valid address");

endmodule // smbarp_slave

/* File: sim/smbarp_master.sv */
`timescale 1ns/1ps
module smbarp_master (
  // Clock
  input wire logic sys_clk,
  // Byte layer requests
  output logic frameStart,
  output logic frameStop,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic txReq,
  output logic txNack,
  // Device answers
  input wire logic ackValid,
  input wire logic ackOk,
  input wire logic txValid,
  input wire logic [7:0] txData
);
  logic [7:0] crc;
  logic [7:0] rxBuf [0:18];
  logic present;
  int nackAt;
  int idx;

  initial begin
    frameStart = 1'b0;
    frameStop = 1'b0;
    rxValid = 1'b0;
    rxData = 8'h00;
    txReq = 1'b0;
    txNack = 1'b0;
    crc = 8'h00;
    present = 1'b0;
    nackAt = -1;
    idx = 0;
  end

  // Checksum step over one byte
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
    end
    return r;
  endfunction

  // Start; a repeated start keeps the running checksum
  task automatic start(input bit rep);
    frameStart = 1'b1;
    if (!rep) begin
      crc = 8'h00;
      nackAt = -1;
      idx = 0;
    end
    @(posedge sys_clk);
    #1;
    frameStart = 1'b0;
  endtask

  task automatic wr(input logic [7:0] b);
    rxValid = 1'b1;
    rxData = b;
    crc = crc8(crc, b);
    @(posedge sys_clk);
    #1;
    rxValid = 1'b0;
    rxData = ~b;
    if (ackValid !== 1'b1 || ackOk !== 1'b1) begin
      if (nackAt < 0) nackAt = idx;
    end
    idx++;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic rd(input int k);
    txReq = 1'b1;
    @(posedge sys_clk);
    #1;
    txReq = 1'b0;
    rxBuf[k] = (txValid === 1'b1) ? txData : 8'hxx;
    if (k < 18) crc = crc8(crc, rxBuf[k]);
    @(posedge sys_clk);
    #1;
  endtask

  task automatic stop();
    frameStop = 1'b1;
    @(posedge sys_clk);
    #1;
    frameStop = 1'b0;
    present = (nackAt < 0);
    @(posedge sys_clk);
    #1;
  endtask

  task automatic reset_cmd(input logic [7:0] cmd, input logic [7:0] bad);
    start(1'b0);
    wr(8'hc2);
    wr(cmd);
    wr(crc ^ bad);
    stop();
  endtask

  task automatic get_id(input logic [7:0] cmd);
    start(1'b0);
    wr(8'hc2);
    wr(cmd);
    start(1'b1);
    wr(8'hc3);
    if (nackAt < 0) begin
      for (int k = 0; k < 19; k++) rd(k);
      if (rxBuf[0] !== 8'h11) nackAt = 0;
      txNack = 1'b1;
      @(posedge sys_clk);
      #1;
      txNack = 1'b0;
    end
    stop();
  endtask

  // Gives up at the first refused byte after the count byte
  task automatic assign_addr(input logic [127:0] id, input logic [7:0] a,
                             input logic [7:0] bad);
    start(1'b0);
    wr(8'hc2);
    wr(8'h04);
    wr(8'h11);
    for (int k = 15; k >= 0; k--) if (nackAt < 0) wr(id[k*8 +: 8]);
    if (nackAt < 0) wr(a);
    if (nackAt < 0) wr(crc ^ bad);
    stop();
  endtask
endmodule // smbarp_master

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam logic [127:0] UID = 128'h0123456789abcdeffedcba9876543210;
  logic sys_clk, reset_n, frameStart, frameStop, rxValid, txReq, txNack;
  logic ackValid, ackOk, txValid, persistWrite, randomRegen;
  logic persistentAddressOption, randomNumberOption, persistValidIn;
  logic addressResolvedFlag, addressValidFlag;
  logic [7:0] rxData, txData;
  logic [127:0] uniqueDeviceIdentifier;
  logic [6:0] persistAddrIn, slaveAddress, persistAddrOut;
  int n_errors = 0;
  int samples_checked = 0;
  int nPersist = 0;
  int nRegen = 0;

  smbarp_slave u_smbarp_slave (
    .sys_clk(sys_clk), .reset_n(reset_n), .frameStart(frameStart),
    .frameStop(frameStop), .rxValid(rxValid), .rxData(rxData),
    .txReq(txReq), .txNack(txNack), .ackValid(ackValid), .ackOk(ackOk),
    .txValid(txValid), .txData(txData),
    .uniqueDeviceIdentifier(uniqueDeviceIdentifier),
    .persistentAddressOption(persistentAddressOption),
    .randomNumberOption(randomNumberOption),
    .persistValidIn(persistValidIn), .persistAddrIn(persistAddrIn),
    .addressResolvedFlag(addressResolvedFlag),
    .addressValidFlag(addressValidFlag), .slaveAddress(slaveAddress),
    .persistWrite(persistWrite), .persistAddrOut(persistAddrOut),
    .randomRegen(randomRegen));

  smbarp_master u_smbarp_master (
    .sys_clk(sys_clk), .frameStart(frameStart), .frameStop(frameStop),
    .rxValid(rxValid), .rxData(rxData), .txReq(txReq), .txNack(txNack),
    .ackValid(ackValid), .ackOk(ackOk), .txValid(txValid),
    .txData(txData));

  always @(posedge sys_clk) begin
    if (persistWrite === 1'b1) nPersist++;
    if (randomRegen === 1'b1) nRegen++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  task automatic chk_fl(input logic [7:0] f);
    chk({6'h00, addressResolvedFlag, addressValidFlag}, f, "flags");
  endtask

  task automatic chk_st(input logic [7:0] f, input logic [7:0] a);
    chk_fl(f);
    chk({1'b0, slaveAddress}, a, "address");
  endtask

  task automatic chk_ack(input logic e);
    chk({7'h00, u_smbarp_master.present}, {7'h00, e}, "ack pattern");
  endtask

  task automatic chk_reply(input logic [7:0] a);
    chk(u_smbarp_master.rxBuf[0], 8'h11, "count");
    for (int k = 1; k < 17; k++) begin
      chk(u_smbarp_master.rxBuf[k], UID[(16-k)*8 +: 8], "id");
    end
    chk(u_smbarp_master.rxBuf[17], a, "reply address");
    chk(u_smbarp_master.rxBuf[18], u_smbarp_master.crc, "pec");
  endtask

  task automatic t_query_unresolved();
    u_smbarp_master.get_id(8'h03);
    chk_ack(1'b1);
    chk_reply(8'hff);
    chk_st(8'h00, 8'h00);
    $display("test query_unresolved done");
  endtask

  task automatic t_assign_refused();
    persistentAddressOption = 1'b1;
    u_smbarp_master.assign_addr(UID ^ (128'hff << 80), 8'h5a, 8'h00);
    chk(u_smbarp_master.nackAt[7:0], 8'h08, "mid id nack");
    uniqueDeviceIdentifier = UID ^ {1'b1, 127'h0};
    u_smbarp_master.assign_addr(UID, 8'h5a, 8'h00);
    uniqueDeviceIdentifier = UID;
    chk(u_smbarp_master.nackAt[7:0], 8'h03, "own id nack");
    u_smbarp_master.assign_addr(UID ^ 128'h1, 8'h5a, 8'h00);
    chk(u_smbarp_master.nackAt[7:0], 8'h12, "last id nack");
    u_smbarp_master.assign_addr(UID, 8'h5a, 8'h01);
    chk(u_smbarp_master.nackAt[7:0], 8'h14, "pec nack");
    chk_st(8'h00, 8'h00);
    chk(nPersist[7:0], 8'h00, "no persist");
    $display("test assign_refused done");
  endtask

  task automatic t_assign_ok();
    u_smbarp_master.assign_addr(UID, 8'h5b, 8'h00);
    chk_ack(1'b1);
    chk_st(8'h03, 8'h2d);
    chk(nPersist[7:0], 8'h01, "persist pulse");
    chk({1'b0, persistAddrOut}, 8'h2d, "persist value");
    u_smbarp_master.get_id(8'h03);
    chk_ack(1'b0);
    u_smbarp_master.get_id(8'h5b);
    chk_ack(1'b1);
    chk_reply(8'h5b);
    u_smbarp_master.get_id(8'h5d);
    chk_ack(1'b0);
    u_smbarp_master.assign_addr(UID, 8'h48, 8'h00);
    chk_st(8'h03, 8'h24);
    chk(nPersist[7:0], 8'h02, "persist again");
    persistentAddressOption = 1'b0;
    $display("test assign_ok done");
  endtask

  task automatic t_directed_reset();
    u_smbarp_master.reset_cmd(8'h5a, 8'h00);
    chk_ack(1'b0);
    u_smbarp_master.reset_cmd(8'h48, 8'h01);
    chk_ack(1'b0);
    chk_st(8'h03, 8'h24);
    u_smbarp_master.reset_cmd(8'h48, 8'h00);
    chk_ack(1'b1);
    chk_fl(8'h00);
    chk(nRegen[7:0], 8'h01, "regen");
    u_smbarp_master.get_id(8'h49);
    chk_ack(1'b0);
    u_smbarp_master.reset_cmd(8'h48, 8'h00);
    chk_ack(1'b0);
    $display("test directed_reset done");
  endtask

  task automatic t_general_reset();
    persistentAddressOption = 1'b1;
    u_smbarp_master.assign_addr(UID, 8'h30, 8'h00);
    u_smbarp_master.reset_cmd(8'h02, 8'h01);
    chk_ack(1'b1);
    chk_st(8'h03, 8'h18);
    u_smbarp_master.reset_cmd(8'h02, 8'h00);
    chk_ack(1'b1);
    chk_st(8'h01, 8'h18);
    chk(nRegen[7:0], 8'h02, "regen");
    persistentAddressOption = 1'b0;
    randomNumberOption = 1'b0;
    u_smbarp_master.reset_cmd(8'h02, 8'h00);
    chk_ack(1'b1);
    chk_fl(8'h00);
    chk(nRegen[7:0], 8'h02, "no regen");
    $display("test general_reset done");
  endtask

  task automatic t_reload();
    persistentAddressOption = 1'b1;
    persistValidIn = 1'b1;
    persistAddrIn = 7'h33;
    reset_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    chk_st(8'h01, 8'h33);
    u_smbarp_master.get_id(8'h67);
    chk_ack(1'b1);
    chk_reply(8'h67);
    $display("test reload done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    reset_n = 1'b0;
    uniqueDeviceIdentifier = UID;
    persistentAddressOption = 1'b0;
    randomNumberOption = 1'b1;
    persistValidIn = 1'b0;
    persistAddrIn = 7'h00;
    repeat (16) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk({6'h00, addressResolvedFlag, addressValidFlag}, 8'h00, "init");
    t_query_unresolved();
    t_assign_refused();
    t_assign_ok();
    t_directed_reset();
    t_general_reset();
    t_reload();
    complete_run();
  end

  initial begin
    #100000;
    n_errors++;
    complete_run();
  end
endmodule // testbench
